/* src/setpoint_pkg.sv */
/*
  Package for the setpoint alarm output block: register map, field
  layout, action and reset-mode encodings, timing constants.
  Assumes a 10 MHz system clock and 32-bit register data.
*/
package setpoint_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned TICK_MS       = 100;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam logic [12:0] DELAY_MAX     = 13'h1_76F; // 5999 tenths
  localparam logic [16:0] HYST_MIN      = 17'h0_0001;
  localparam logic [16:0] HYST_MAX      = 17'h0_EA5F; // 59999
  localparam logic [17:0] SETP_MAX      = 18'h1_869F; // 99999
  localparam logic [17:0] SETP_MIN      = 18'h3_B1E1; // -19999

  // ----------------------------------------------------------------
  // register map, index = address
  // ----------------------------------------------------------------
  localparam int unsigned AW            = 6;
  localparam logic [5:0] CH_STRIDE      = 6'h08;
  localparam logic [2:0] REG_CFG        = 3'h0;
  localparam logic [2:0] REG_SETP       = 3'h1;
  localparam logic [2:0] REG_HYST       = 3'h2;
  localparam logic [2:0] REG_DON        = 3'h3;
  localparam logic [2:0] REG_DOFF       = 3'h4;
  localparam logic [2:0] REG_STAT       = 3'h5;
  localparam logic [5:0] REG_CMD        = 6'h3F; // serial reset command

  // cfg field positions
  localparam int unsigned CFG_EN        = 0;
  localparam int unsigned CFG_ACT       = 1; // 2 bits
  localparam int unsigned CFG_RST       = 3; // 2 bits
  localparam int unsigned CFG_DSPRST    = 5;
  localparam int unsigned CFG_STBY      = 6;
  localparam int unsigned CFG_COLOR     = 7;
  localparam logic [7:0]  CFG_RESET     = 8'h01;
  localparam logic [17:0] SETP_RESET    = 18'h0_0000;
  localparam logic [16:0] HYST_RESET    = 17'h0_0001;
  localparam logic [12:0] DELAY_RESET   = 13'h0_000;

  typedef enum logic [1:0] {
    high_balanced_action,
    low_balanced_action,
    high_unbalanced_action,
    low_unbalanced_action
  } action_t;

  typedef enum logic [1:0] {
    auto_mode,
    latch_immediate_mode,
    latch_deferred_mode,
    spare_mode
  } reset_mode_t;

  typedef struct packed {
    logic        color_chg;
    logic        standby;
    logic        disp_reset;
    reset_mode_t rmode;
    action_t     action;
    logic        enable;
  } cfg_t;

  // register bus request
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [31:0]   wdata;
    logic          we;
    logic          re;
  } bus_req_t;

  // reset requests presented by front panel and user input
  typedef struct packed {
    logic manual;        // button or user input, one-cycle pulse
    logic src_is_disp;   // that source assigned to display_reset_function
    logic input_shown;   // input value is on display
  } rst_req_t;

endpackage

/* src/setpoint_alarm_output.sv */
/*
  Setpoint alarm output: compares the scaled display value against
  per-channel setpoints and drives one output per channel.
  Assumes display value and reset requests synchronous to clk_i;
  power-up is the release of rstn_i.
*/
// How it works
// RL1: disabled second setpoint never activates output
// RL2: four actions, high/low, balanced/unbalanced
// RL3: signed setpoint -19999..99999 versus display
// RL4: all quantities in same display counts
// RL5: hysteresis programmable 1..59999, zero refused
// RL6: unbalanced: off at setpoint minus/plus hysteresis
// RL7: balanced band centred on setpoint
// RL8: on delay 0.0..599.9 s in tenths
// RL9: separate off delay 0.0..599.9 s
// RL10: zero delay follows comparison directly
// RL11: auto mode turns off at off point
// RL12: auto mode manual reset clears at once
// RL13: latch modes hold until reset or power
// RL14: immediate latch reset clears at once
// RL15: power-up below setpoint leaves latch off
// RL16: deferred latch reset waits for off point
// RL17: power cycle discards pending deferred reset
// RL18: display reset also resets output if enabled
// RL19: only when source is display reset, input shown
// RL20: standby holds off until first trigger; code copies the reset standby bit 0 at power-up, so never holds off
// RL21: toggle backlight colour on output change
// RL22: channel count set by output card
// RL23: delays count tenth ticks, restart on drop
`timescale 1ns/100ps
`default_nettype none

module setpoint_alarm_output
  import setpoint_pkg::*;
#(
  parameter int unsigned N_CH        = 2,          // see RL22
  parameter int unsigned TICK_CNT    = TICK_CYCLES
) (
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic [17:0]       disp_value_i,  // signed display counts
  input  wire rst_req_t          rst_req_i,
  input  wire logic [AW-1:0]     bus_addr_i,
  input  wire logic [31:0]       bus_wdata_i,
  input  wire logic              bus_we_i,
  input  wire logic              bus_re_i,
  output logic [31:0]            bus_rdata_o,
  output logic [N_CH-1:0]        sp_out_o,
  output logic [N_CH-1:0]        color_o
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_s1_q, rst_s2_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire logic rst_n = rst_s2_q;

  // ----------------------------------------------------------------
  // timebase: one tenth second enable
  // ----------------------------------------------------------------
  logic [23:0] tb_q;
  logic        tick_q;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tb_q   <= 24'h00_0000;
      tick_q <= 1'b0;
    end else if (tb_q == 24'(TICK_CNT - 1)) begin
      tb_q   <= 24'h00_0000;
      tick_q <= 1'b1;                                   // see RL23
    end else begin
      tb_q   <= tb_q + 24'h00_0001;
      tick_q <= 1'b0;
    end
  end

  // power-up marker, one cycle after release
  logic pwr_q;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) pwr_q <= 1'b1;
    else        pwr_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // register bus decode
  // ----------------------------------------------------------------
  wire logic [2:0] sel_reg = bus_addr_i[2:0];
  wire logic [2:0] sel_ch  = bus_addr_i[5:3];
  wire logic       cmd_hit = bus_we_i && (bus_addr_i == REG_CMD);
  // serial reset command: bit n resets channel n
  wire logic [N_CH-1:0] ser_rst = cmd_hit ? bus_wdata_i[N_CH-1:0] : '0;

  logic [31:0] rd_mux [N_CH];
  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = 32'h0000_0000;  // unmapped reads as zero
    for (int i = 0; i < N_CH; i++) begin
      if (sel_ch == 3'(i)) rdata_d = rd_mux[i];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n)        bus_rdata_o <= 32'h0000_0000;
    else if (bus_re_i) bus_rdata_o <= rdata_d;
    else               bus_rdata_o <= 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // per-channel logic
  // ----------------------------------------------------------------
  // display reset path resets outputs only under both conditions
  wire logic disp_rst = rst_req_i.manual && rst_req_i.src_is_disp
                        && rst_req_i.input_shown;       // see RL19

  for (genvar c = 0; c < N_CH; c++) begin : g_ch
    cfg_t        cfg_q;
    logic [17:0] setp_q;
    logic [16:0] hyst_q;
    logic [12:0] don_q, doff_q, cnt_q;
    logic        out_q, color_q, pend_q, stby_q, first_q;
    logic        out_d_q;       // previous output, for change detection

    wire logic wr = bus_we_i && (sel_ch == 3'(c));

    // compare in display counts, 20-bit signed to avoid overflow; see RL4
    wire logic signed [19:0] pv  = 20'(signed'(disp_value_i));
    wire logic signed [19:0] sp  = 20'(signed'(setp_q));           // see RL3
    wire logic signed [19:0] hy  = signed'({3'b000, hyst_q});
    wire logic signed [19:0] hh  = signed'({4'b0000, hyst_q[16:1]});
    wire logic is_high = (cfg_q.action == high_balanced_action) ||
                         (cfg_q.action == high_unbalanced_action);
    wire logic is_bal  = (cfg_q.action == high_balanced_action) ||
                         (cfg_q.action == low_balanced_action);     // see RL2
    // on / off trigger points
    wire logic signed [19:0] on_pt  = is_bal ? (is_high ? sp + hh : sp - hh)
                                             : sp;                  // see RL7
    wire logic signed [19:0] off_pt = is_bal ? (is_high ? sp - hh : sp + hh)
                                             : (is_high ? sp - hy : sp + hy); // see RL6
    wire logic on_cond  = is_high ? (pv >= on_pt)  : (pv <= on_pt);
    wire logic off_cond = is_high ? (pv <  off_pt) : (pv >  off_pt);  // see RL11
    wire logic latched  = (cfg_q.rmode == latch_immediate_mode) ||
                          (cfg_q.rmode == latch_deferred_mode);
    // second setpoint can be disabled; first always enabled
    wire logic active   = (c != 1) || cfg_q.enable;                  // see RL1
    wire logic man_rst  = (rst_req_i.manual && !rst_req_i.src_is_disp)
                          || ser_rst[c] || (cfg_q.disp_reset && disp_rst); // see RL18
    wire logic below_sp = is_high ? (pv < sp) : (pv > sp);

    wire logic want_on  = on_cond  && !out_q && !first_q;
    wire logic want_off = off_cond &&  out_q && (!latched || pend_q);
    wire logic [12:0] dly = want_on ? don_q : doff_q;
    wire logic expired  = (dly == 13'h0_000) || (cnt_q >= dly);  // see RL10

    // configuration writes; hysteresis zero is refused
    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        cfg_q  <= cfg_t'(CFG_RESET);
        setp_q <= SETP_RESET;
        hyst_q <= HYST_RESET;
        don_q  <= DELAY_RESET;
        doff_q <= DELAY_RESET;
      end else if (wr) begin
        case (sel_reg)
          REG_CFG:  cfg_q  <= cfg_t'(bus_wdata_i[7:0]);
          REG_SETP: if (signed'(bus_wdata_i[17:0]) <= signed'(SETP_MAX) &&
                        signed'(bus_wdata_i[17:0]) >= signed'(SETP_MIN))
                      setp_q <= bus_wdata_i[17:0];                   // see RL3
          REG_HYST: if (bus_wdata_i[16:0] >= HYST_MIN &&
                        bus_wdata_i[16:0] <= HYST_MAX)
                      hyst_q <= bus_wdata_i[16:0];                   // see RL5
          REG_DON:  if (bus_wdata_i[12:0] <= DELAY_MAX)
                      don_q  <= bus_wdata_i[12:0];                   // see RL8
          REG_DOFF: if (bus_wdata_i[12:0] <= DELAY_MAX)
                      doff_q <= bus_wdata_i[12:0];                   // see RL9
          default: ;
        endcase
      end
    end

    // delay counter restarts whenever the pending condition drops
    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n)                    cnt_q <= 13'h0_000;
      else if (!(want_on||want_off)) cnt_q <= 13'h0_000;           // see RL23
      else if (tick_q && !expired)   cnt_q <= cnt_q + 13'h0_001;
    end

    // output state
    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        out_q   <= 1'b0;
        pend_q  <= 1'b0;                                            // see RL17
        stby_q  <= 1'b1;
        first_q <= 1'b0;
        color_q <= 1'b0;
      end else begin
        // first cycle: output forced off; standby taken from cfg_q, which still holds its reset value 0
        if (pwr_q) begin
          first_q <= cfg_q.standby;                                 // see RL20
          stby_q  <= 1'b0;
          out_q   <= 1'b0;                                          // see RL15
        end else if (!active) begin
          out_q  <= 1'b0;
          pend_q <= 1'b0;
        end else begin
          if (first_q && !on_cond) first_q <= 1'b0;  // armed on first crossing
          if (man_rst && out_q && cfg_q.rmode == latch_deferred_mode)
            pend_q <= 1'b1;                                         // see RL16
          if (man_rst && out_q && cfg_q.rmode != latch_deferred_mode) begin
            out_q <= 1'b0;                                    // see RL12 RL14
            first_q <= 1'b1;          // stays off until crossed again
          end else if (want_on && expired) begin
            out_q <= 1'b1;                                          // see RL13
          end else if (want_off && expired) begin
            out_q  <= 1'b0;
            pend_q <= 1'b0;
          end
        end
        if (cfg_q.color_chg && (out_q != out_d_q)) color_q <= ~color_q; // see RL21
      end
    end

    // previous output for change detection
    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) out_d_q <= 1'b0;
      else        out_d_q <= out_q;
    end

    assign sp_out_o[c] = out_q;
    assign color_o[c]  = color_q;

    // readback, status shows live state
    always_comb begin
      case (sel_reg)
        REG_CFG:  rd_mux[c] = {24'h00_0000, cfg_q};
        REG_SETP: rd_mux[c] = {{14{setp_q[17]}}, setp_q};
        REG_HYST: rd_mux[c] = {15'h0000, hyst_q};
        REG_DON:  rd_mux[c] = {19'h0_0000, don_q};
        REG_DOFF: rd_mux[c] = {19'h0_0000, doff_q};
        REG_STAT: rd_mux[c] = {27'h000_0000, stby_q, first_q, pend_q,
                               color_q, out_q};
        default:  rd_mux[c] = 32'h0000_0000;
      endcase
    end
  end

endmodule // setpoint_alarm_output

`default_nettype wire

/* test/setpoint_alarm_props.sv */
/* Port checker for the setpoint alarm output block.
   Assumes channel 0 and 1 config is written with legal values only. */
`timescale 1ns/100ps
`default_nettype none
module setpoint_alarm_props
  import setpoint_pkg::*;
#(
  parameter int unsigned N_CH = 2
) (
  input wire logic            clk_i,
  input wire logic            rstn_i,
  input wire logic [17:0]     disp_value_i,
  input wire rst_req_t        rst_req_i,
  input wire logic [AW-1:0]   bus_addr_i,
  input wire logic [31:0]     bus_wdata_i,
  input wire logic            bus_we_i,
  input wire logic            bus_re_i,
  input wire logic [31:0]     bus_rdata_o,
  input wire logic [N_CH-1:0] sp_out_o,
  input wire logic [N_CH-1:0] color_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ------------------------------------------------------------
  // config shadow, snooped off the bus
  // ------------------------------------------------------------
  cfg_t cfg0_q;
  logic en1_q;
  wire  ser_wr = bus_we_i && bus_addr_i == REG_CMD && bus_wdata_i[0];
  wire  clr    = rst_req_i.manual || ser_wr;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg0_q <= cfg_t'(CFG_RESET);
      en1_q  <= 1'b1;
    end else begin
      if (bus_we_i && bus_addr_i == 6'h00) cfg0_q <= cfg_t'(bus_wdata_i[7:0]);
      if (bus_we_i && bus_addr_i == 6'h08) en1_q <= bus_wdata_i[0];
    end
  end
  // a plain manual reset outside the deferred latch mode
  sequence manual_req;
    rst_req_i.manual && !rst_req_i.src_is_disp && cfg0_q.rmode != latch_deferred_mode;
  endsequence
  sequence out0_cleared;
    ##[1:2] !sp_out_o[0];
  endsequence
  rd_idle_a: assert property (!$past(bus_re_i) |-> bus_rdata_o == 32'h0000_0000)
    else $error("read data not zero outside read");
  cfg_rdback_a: assert property ($past(bus_re_i) && $past(bus_addr_i) == 6'h00
    |-> bus_rdata_o[7:0] == cfg0_q) else $error("cfg readback wrong");
  // colour follows one cycle behind the output edge that moves it
  color_tie_a: assert property (((color_o ^ $past(color_o)) &
    ~($past(sp_out_o) ^ $past(sp_out_o, 2))) == '0)
    else $error("colour moved without output change");
  ch1_off_a: assert property (!en1_q && !$past(en1_q, 2) |-> !sp_out_o[1])
    else $error("disabled channel output on");
  manual_clr_a: assert property (manual_req |-> out0_cleared)
    else $error("manual reset did not clear output");
  serial_clr_a: assert property (ser_wr && cfg0_q.rmode == latch_immediate_mode
    |-> ##[1:3] !sp_out_o[0]) else $error("serial reset did not clear output");
  latch_hold_a: assert property ($fell(sp_out_o[0]) && cfg0_q.rmode == latch_immediate_mode
    |-> $past(clr) || $past(clr, 2) || $past(clr, 3))
    else $error("latched output dropped on its own");
  boot_quiet_a: assert property ($rose(rstn_i) |-> (sp_out_o == '0) [*2])
    else $error("output active at power-up");
endmodule // setpoint_alarm_props
bind setpoint_alarm_output setpoint_alarm_props #(.N_CH(N_CH)) props_i (
  .clk_i(clk_i), .rstn_i(rstn_i), .disp_value_i(disp_value_i), .rst_req_i(rst_req_i),
  .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_we_i(bus_we_i),
  .bus_re_i(bus_re_i), .bus_rdata_o(bus_rdata_o), .sp_out_o(sp_out_o), .color_o(color_o));
`default_nettype wire

/* test/relay_card_model.sv */
/* Output card model: one relay per setpoint channel.
   Assumes coil drive is a registered level from the meter. */
`timescale 1ns/100ps
`default_nettype none
module relay_card_model #(
  parameter int unsigned N_CH = 2
) (
  input  wire logic            clk_i,
  input  wire logic            rstn_i,
  input  wire logic [N_CH-1:0] coil_i,
  output var  logic [N_CH-1:0] contact_o
);
  // contacts pull in a clock late; a dead card drops every relay
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) contact_o <= '0;
    else contact_o <= coil_i;
  end
endmodule // relay_card_model
`default_nettype wire

/* test/setpoint_alarm_output_tb.sv */
/* Testbench for the setpoint alarm output block.
   Assumes short tick of 10 cycles, so one delay tenth is 1 us. */
`timescale 1ns/100ps
`default_nettype none
module setpoint_alarm_output_tb;
  import setpoint_pkg::*;
  localparam logic [17:0] HI = 18'h0_0096; // 150, above setpoint 100
  logic          clk_i, rstn_i, bus_we_i, bus_re_i;
  logic [17:0]   disp_value_i;
  rst_req_t      rst_req_i;
  logic [AW-1:0] bus_addr_i;
  logic [31:0]   bus_wdata_i, bus_rdata_o;
  logic [1:0]    sp_out_o, color_o, contact;
  int            bad_count, total_checks;
  setpoint_alarm_output #(.N_CH(2), .TICK_CNT(10)) DUT (.clk_i(clk_i), .rstn_i(rstn_i),
    .disp_value_i(disp_value_i), .rst_req_i(rst_req_i), .bus_addr_i(bus_addr_i),
    .bus_wdata_i(bus_wdata_i), .bus_we_i(bus_we_i), .bus_re_i(bus_re_i),
    .bus_rdata_o(bus_rdata_o), .sp_out_o(sp_out_o), .color_o(color_o));
  relay_card_model #(.N_CH(2)) card (.clk_i(clk_i), .rstn_i(rstn_i), .coil_i(sp_out_o),
    .contact_o(contact));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // ------------------------------------------------------------
  // bus and check tasks
  // ------------------------------------------------------------
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(logic [5:0] a, logic [31:0] d);
    @(posedge clk_i);
    bus_we_i <= 1'b1; bus_addr_i <= a; bus_wdata_i <= d;
    @(posedge clk_i);
    bus_we_i <= 1'b0;
  endtask
  task automatic rd(logic [5:0] a, logic [31:0] e);
    @(posedge clk_i);
    bus_re_i <= 1'b1; bus_addr_i <= a;
    @(posedge clk_i);
    bus_re_i <= 1'b0;
    #1 chk("rdata", e, bus_rdata_o);
  endtask
  // settle a few cycles first: output is registered behind the compare
  task automatic ochk(int ch, logic e, int n = 6);
    repeat (n) @(posedge clk_i);
    #1 chk("sp_out", {31'h0, e}, {31'h0, sp_out_o[ch]});
  endtask
  task automatic setd(logic [17:0] v);
    @(posedge clk_i);
    disp_value_i <= v;
  endtask
  task automatic pulse(logic [2:0] r); // {manual, src_is_disp, input_shown}
    @(posedge clk_i);
    rst_req_i <= r;
    @(posedge clk_i);
    rst_req_i <= 3'b000;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    $display("FAIL watchdog exp done got hang");
    final_report();
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    {rstn_i, bus_we_i, bus_re_i, bad_count, total_checks} = '0;
    {disp_value_i, rst_req_i, bus_addr_i, bus_wdata_i} = '0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd(6'h00, 32'h0000_0001);
    rd(6'h02, 32'h0000_0001);
    rd(6'h06, 32'h0000_0000);
    wr(6'h01, 32'h0000_0064);
    wr(6'h02, 32'h0000_0000);
    rd(6'h02, 32'h0000_0001);
    wr(6'h02, 32'h0000_000A);
    wr(6'h01, 32'h0001_86A0);
    rd(6'h01, 32'h0000_0064);
    $display("registers done");
    wr(6'h00, 32'h0000_0005);
    setd(HI); ochk(0, 1'b1);
    chk("relay", 32'h1, {31'h0, contact[0]});
    ochk(1, 1'b1);
    wr(6'h08, 32'h0000_0000); ochk(1, 1'b0);
    setd(18'h0_005F); ochk(0, 1'b1);
    setd(18'h0_0059); ochk(0, 1'b0);
    setd(HI); ochk(0, 1'b1);
    pulse(3'b101); ochk(0, 1'b0);
    $display("auto done");
    wr(6'h00, 32'h0000_0025); setd(18'h0_0000); ochk(0, 1'b0);
    setd(HI); ochk(0, 1'b1);
    pulse(3'b110); ochk(0, 1'b1);
    pulse(3'b111); ochk(0, 1'b0);
    $display("display reset done");
    wr(6'h00, 32'h0000_0005); wr(6'h03, 32'h0000_0005); setd(18'h0_0000); ochk(0, 1'b0);
    setd(HI); ochk(0, 1'b0, 30); ochk(0, 1'b1, 40);
    wr(6'h03, 32'h0000_0000); wr(6'h04, 32'h0000_0005);
    setd(18'h0_0000); ochk(0, 1'b1, 30); ochk(0, 1'b0, 40);
    wr(6'h04, 32'h0000_0000);
    $display("delays done");
    wr(6'h00, 32'h0000_000D); setd(HI); ochk(0, 1'b1);
    setd(18'h0_0000); ochk(0, 1'b1);
    pulse(3'b101); ochk(0, 1'b0);
    setd(HI); ochk(0, 1'b1);
    pulse(3'b101); ochk(0, 1'b0, 30);
    setd(18'h0_0000); ochk(0, 1'b0); setd(HI); ochk(0, 1'b1);
    wr(6'h3F, 32'h0000_0001); ochk(0, 1'b0);
    wr(6'h00, 32'h0000_0015); setd(18'h0_0000); ochk(0, 1'b0);
    setd(HI); ochk(0, 1'b1);
    pulse(3'b101); ochk(0, 1'b1);
    setd(18'h0_0000); ochk(0, 1'b0);
    $display("latch done");
    wr(6'h00, 32'h0000_0007); setd(18'h0_0032); ochk(0, 1'b1);
    setd(18'h0_0069); ochk(0, 1'b1);
    setd(18'h0_006F); ochk(0, 1'b0);
    wr(6'h00, 32'h0000_0085); setd(18'h0_0000); ochk(0, 1'b0);
    chk("color", 32'h0, {31'h0, color_o[0]});
    setd(HI); ochk(0, 1'b1);
    chk("color", 32'h1, {31'h0, color_o[0]});
    $display("action and colour done");
    final_report();
  end
endmodule // setpoint_alarm_output_tb
`default_nettype wire
